// [hw/thermal_alert_regs.sv]
/*
 * alert mask, extended-resolution, configuration, assertion timer and
 * limit registers of a thermal and fan monitor, with its alert status.
 * assumes the conversion engine, fan fault detection and pwm generator
 * run on clk_i; the thermal pin arrives asynchronously, active low.
 */
`timescale 1ns/1ps

// Operation
// - overtemp mask bit suppresses alert, read-only
// - mask bits 2-4 suppress fan 1-3 alerts
// - bit 5 masks fan 4 or timer event
// - bits 6-7 mask remote diode faults
// - voltage low bits at 1:0 and 5:4
// - low-bits read freezes readings until high read
// - temperature low bits at 3:2, 5:4, 7:6
// - config bit 0 makes pwm2 pin alert
// - config bit 1 enables thermal pin monitoring
// - full_speed_on_thermal forces all fans full on assertion
// - fast bit measures tach every 250 ms
// - bits 4-7 enable continuous tach per input
// - timer bits 7:1 zero below 45.52 ms
// - bit 0 set on assertion, cleared on read
// - bit 0 becomes lsb of 22.76 ms count
// - duration beyond limit raises status bit 5
module thermal_alert_regs #(
	parameter int unsigned TICK_CYCLES = thermal_regs_pkg::TICK_CYCLES,
	parameter int unsigned TACH_CYCLES = thermal_regs_pkg::TACH_FAST_CYCLES,
	parameter int unsigned NUM_FANS = 4
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic adc_valid_i,
	input wire logic [2:0] adc_chan_i,
	input wire logic [9:0] adc_data_i,
	input wire logic overtemp_i,
	input wire logic [3:0] fan_fault_i,
	input wire logic [1:0] diode_fault_i,
	input wire logic input_four_thermal_i,
	input wire logic thermal_pin_n_i,
	input wire logic [NUM_FANS-1:0] fan_pwm_i,
	input wire logic pwm2_i,
	output logic [NUM_FANS-1:0] fan_pwm_o,
	output logic pwm2_pin_o,
	output logic pwm2_pin_oe_n_o,
	output logic irq_o,
	output logic tach_sample_o,
	output logic tach_fast_o,
	output logic [3:0] tach_continuous_o
);

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int TACH_W = $clog2(TACH_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
	localparam logic [TACH_W-1:0] TACH_LAST = TACH_W'(TACH_CYCLES - 1);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [1:0] low2(input logic [9:0] v);
		low2 = v[1:0];
	endfunction

	logic [7:0] cfg_reg;
	logic [7:0] mask_reg;
	logic [7:0] limit_reg;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic [9:0] res_reg [thermal_regs_pkg::NUM_CHAN];
	logic [1:0] pend_volt_reg;
	logic [2:0] pend_temp_reg;
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic asserted_d_reg;
	logic [TICK_W-1:0] tick_cnt_reg;
	logic [7:0] run_reg;
	logic [7:0] dur_reg;
	logic assert_flag_reg;
	logic [TACH_W-1:0] tach_cnt_reg;
	logic [1:0] quarter_reg;
	logic [7:0] rdata_reg;
	logic irq_reg;
	logic [NUM_FANS-1:0] fan_pwm_reg;
	logic pwm2_pin_reg;
	logic pwm2_oe_n_reg;
	logic tach_sample_reg;

	logic rd_en;
	logic wr_en;
	logic monitor_on;
	logic asserted;
	logic rise;
	logic tick;
	logic timer_event;
	logic [7:0] mask_eff;
	logic [7:0] events;
	logic [7:0] timer_value;
	logic [7:0] rd_value;
	logic alert_now;
	logic [7:0] res_off;

	assign rd_en = rd_i && ce_i;
	assign wr_en = wr_i && ce_i;
	assign res_off = addr_i - thermal_regs_pkg::OFF_RESULT_BASE;
	assign monitor_on = cfg_reg[thermal_regs_pkg::CFG_MONITOR] && input_four_thermal_i;
	assign asserted = monitor_on && pin_sync_reg;
	assign rise = asserted && !asserted_d_reg;
	assign tick = asserted && !rise && (tick_cnt_reg == TICK_LAST);

	// overtemp mask is not writable: it follows monitoring, masked while off
	assign mask_eff = (mask_reg & thermal_regs_pkg::MASK_WRITABLE)
		| (8'h01 << thermal_regs_pkg::BIT_OVERTEMP) & {8{!monitor_on}};

	// limit of zero fires on the edge itself, 0xff never, otherwise at most once per assertion
	assign timer_event = (limit_reg == 8'h00) ? rise
		: (tick && run_reg == limit_reg && run_reg != 8'hff);

	always_comb begin
		events = 8'h00;
		events[thermal_regs_pkg::BIT_OVERTEMP] = overtemp_i;
		events[thermal_regs_pkg::BIT_FAN_ONE +: 3] = fan_fault_i[2:0];
		events[thermal_regs_pkg::BIT_FAN_FOUR] = input_four_thermal_i ? timer_event
			: fan_fault_i[3];
		events[thermal_regs_pkg::BIT_DIODE_ONE +: 2] = diode_fault_i;
	end

	// set wins over a write-one-to-clear in the same cycle
	always_comb begin
		status_next = status_reg;
		if (wr_en && hit(addr_i, thermal_regs_pkg::OFF_ALERT_STATUS)) begin
			status_next = status_reg & ~wdata_i;
		end
		status_next = (status_next | events) & thermal_regs_pkg::STATUS_USED;
	end

	assign alert_now = |(status_reg & ~mask_eff);

	always_comb begin
		if (dur_reg >= thermal_regs_pkg::THRESH_TICKS) begin
			timer_value = dur_reg;
		end else begin
			timer_value = {7'h00, assert_flag_reg};
		end
	end

	always_comb begin
		rd_value = 8'h00;
		if (hit(addr_i, thermal_regs_pkg::OFF_ALERT_MASK)) begin
			rd_value = mask_eff;
		end else if (hit(addr_i, thermal_regs_pkg::OFF_VOLT_LOW)) begin
			rd_value = {2'b00, low2(res_reg[thermal_regs_pkg::CH_VCC]), 2'b00,
				low2(res_reg[thermal_regs_pkg::CH_V25])};
		end else if (hit(addr_i, thermal_regs_pkg::OFF_TEMP_LOW)) begin
			rd_value = {low2(res_reg[thermal_regs_pkg::CH_REM2]),
				low2(res_reg[thermal_regs_pkg::CH_LOCAL]),
				low2(res_reg[thermal_regs_pkg::CH_REM1]), 2'b00};
		end else if (hit(addr_i, thermal_regs_pkg::OFF_CONFIG)) begin
			rd_value = cfg_reg;
		end else if (hit(addr_i, thermal_regs_pkg::OFF_TIMER)) begin
			rd_value = timer_value;
		end else if (hit(addr_i, thermal_regs_pkg::OFF_LIMIT)) begin
			rd_value = limit_reg;
		end else if (hit(addr_i, thermal_regs_pkg::OFF_ALERT_STATUS)) begin
			rd_value = status_reg;
		end else if (res_off < 8'(thermal_regs_pkg::NUM_CHAN)) begin
			rd_value = res_reg[res_off[2:0]][9:2];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_reg <= 8'h00;
		end else if (ce_i) begin
			rdata_reg <= rd_i ? rd_value : 8'h00;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_reg <= thermal_regs_pkg::CONFIG_RESET;
			mask_reg <= thermal_regs_pkg::MASK_RESET;
			limit_reg <= thermal_regs_pkg::LIMIT_RESET;
		end else if (wr_en) begin
			if (hit(addr_i, thermal_regs_pkg::OFF_CONFIG)) begin
				cfg_reg <= wdata_i;
			end
			if (hit(addr_i, thermal_regs_pkg::OFF_ALERT_MASK)) begin
				mask_reg <= wdata_i & thermal_regs_pkg::MASK_WRITABLE;
			end
			if (hit(addr_i, thermal_regs_pkg::OFF_LIMIT)) begin
				limit_reg <= wdata_i;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_reg <= 8'h00;
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			status_reg <= status_next;
			irq_reg <= |(status_next & ~mask_eff);
		end
	end

	// a low-bits read freezes its group until every high byte of it is read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_volt_reg <= 2'b00;
			pend_temp_reg <= 3'b000;
		end else if (rd_en) begin
			if (hit(addr_i, thermal_regs_pkg::OFF_VOLT_LOW)) begin
				pend_volt_reg <= 2'b11;
			end else if (hit(addr_i, thermal_regs_pkg::OFF_TEMP_LOW)) begin
				pend_temp_reg <= 3'b111;
			end else if (res_off < 8'(thermal_regs_pkg::CH_REM1)) begin
				pend_volt_reg[res_off[0]] <= 1'b0;
			end else if (res_off < 8'(thermal_regs_pkg::NUM_CHAN)) begin
				pend_temp_reg[2'(res_off[2:0] - thermal_regs_pkg::CH_REM1)] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < thermal_regs_pkg::NUM_CHAN; i++) begin
				res_reg[i] <= 10'h000;
			end
		end else if (ce_i && adc_valid_i && adc_chan_i <= thermal_regs_pkg::CH_REM2) begin
			if (adc_chan_i < thermal_regs_pkg::CH_REM1 ? !(|pend_volt_reg)
				: !(|pend_temp_reg)) begin
				res_reg[adc_chan_i] <= adc_data_i;
			end
		end
	end

	// pin is active low and asynchronous
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
			asserted_d_reg <= 1'b0;
		end else if (ce_i) begin
			pin_meta_reg <= !thermal_pin_n_i;
			pin_sync_reg <= pin_meta_reg;
			asserted_d_reg <= asserted;
		end
	end

	// tick phase restarts with each assertion so the first tick is a full period
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt_reg <= '0;
			run_reg <= 8'h00;
		end else if (ce_i) begin
			if (!asserted || rise || tick) begin
				tick_cnt_reg <= '0;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 1'b1;
			end
			if (rise) begin
				run_reg <= 8'h00;
			end else if (tick && run_reg != 8'hff) begin
				run_reg <= run_reg + 8'h01;
			end
		end
	end

	// duration accumulates between reads and saturates at full scale
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dur_reg <= thermal_regs_pkg::TIMER_RESET;
			assert_flag_reg <= 1'b0;
		end else if (ce_i) begin
			if (rise) begin
				assert_flag_reg <= 1'b1;
			end else if (rd_i && hit(addr_i, thermal_regs_pkg::OFF_TIMER)) begin
				assert_flag_reg <= 1'b0;
			end
			if (rd_i && hit(addr_i, thermal_regs_pkg::OFF_TIMER)) begin
				dur_reg <= {7'h00, tick};
			end else if (tick && dur_reg != 8'hff) begin
				dur_reg <= dur_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fan_pwm_reg <= '0;
		end else if (ce_i) begin
			if (cfg_reg[thermal_regs_pkg::CFG_FULL_SPEED_ON_THERMAL] && asserted) begin
				fan_pwm_reg <= '1;
			end else begin
				fan_pwm_reg <= fan_pwm_i;
			end
		end
	end

	// in alert mode the pin is open drain: drive low only while alerting
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pwm2_pin_reg <= 1'b0;
			pwm2_oe_n_reg <= 1'b1;
		end else if (ce_i) begin
			if (cfg_reg[thermal_regs_pkg::CFG_ALERT_PIN]) begin
				pwm2_pin_reg <= 1'b0;
				pwm2_oe_n_reg <= !alert_now;
			end else begin
				pwm2_pin_reg <= pwm2_i;
				pwm2_oe_n_reg <= 1'b0;
			end
		end
	end

	// slow rate is every fourth fast period, so a rate change never glitches
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tach_cnt_reg <= '0;
			quarter_reg <= 2'b00;
			tach_sample_reg <= 1'b0;
		end else if (ce_i) begin
			tach_sample_reg <= 1'b0;
			if (tach_cnt_reg == TACH_LAST) begin
				tach_cnt_reg <= '0;
				quarter_reg <= quarter_reg + 2'b01;
				tach_sample_reg <= cfg_reg[thermal_regs_pkg::CFG_FAST]
					|| quarter_reg == thermal_regs_pkg::TACH_SLOW_LAST;
			end else begin
				tach_cnt_reg <= tach_cnt_reg + 1'b1;
			end
		end
	end

	assign rdata_o = rdata_reg;
	assign irq_o = irq_reg;
	assign fan_pwm_o = fan_pwm_reg;
	assign pwm2_pin_o = pwm2_pin_reg;
	assign pwm2_pin_oe_n_o = pwm2_oe_n_reg;
	assign tach_sample_o = tach_sample_reg;
	assign tach_fast_o = cfg_reg[thermal_regs_pkg::CFG_FAST];
	assign tach_continuous_o = cfg_reg[thermal_regs_pkg::CFG_CONT_LO +: 4];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_overtemp_masked: assert property (
		ce_i && !monitor_on && status_next == 8'h02 |=> !irq_o)
		else $error("overtemp alert not masked");
	chk_fault_masked: assert property (
		ce_i && (status_next & ~mask_eff) == 8'h00 |=> !irq_o)
		else $error("masked fault raised interrupt");
	chk_timer_route: assert property (
		ce_i && input_four_thermal_i && timer_event |=> status_reg[5] && irq_o == !mask_eff[5])
		else $error("timer event not routed to bit 5");
	chk_volt_layout: assert property (
		rd_en && hit(addr_i, thermal_regs_pkg::OFF_VOLT_LOW) |=>
		rdata_o == {2'b00, $past(res_reg[1][1:0]), 2'b00, $past(res_reg[0][1:0])})
		else $error("voltage low bits misplaced");
	chk_freeze_hold: assert property (
		ce_i && (|pend_temp_reg) |=> res_reg[3] == $past(res_reg[3]))
		else $error("frozen reading changed");
	chk_alert_pin: assert property (
		ce_i && cfg_reg[0] && alert_now |=> !pwm2_pin_oe_n_o && !pwm2_pin_o)
		else $error("alert pin not driven low");
	chk_full_speed_on_thermal_full: assert property (
		ce_i && cfg_reg[2] && asserted |=> fan_pwm_o == '1)
		else $error("full_speed_on_thermal did not force full duty");
	chk_timer_zero: assert property (
		rd_en && hit(addr_i, thermal_regs_pkg::OFF_TIMER) && dur_reg < 8'h02 |=>
		rdata_o[7:1] == 7'h00)
		else $error("timer high bits nonzero below threshold");
	chk_assert_flag: assert property (
		ce_i && rise |=> assert_flag_reg ##0 (timer_value[0] || dur_reg >= 8'h02))
		else $error("assertion flag not set");
	chk_limit_zero: assert property (
		ce_i && rise && limit_reg == 8'h00 && input_four_thermal_i |=> status_reg[5])
		else $error("zero limit did not fire on assertion");

	cov_full_speed_on_thermal: cover property (ce_i && cfg_reg[2] && rise);
	cov_timer_event: cover property (ce_i && timer_event && !(limit_reg == 8'h00));
	cov_freeze_release: cover property (|pend_volt_reg ##1 !(|pend_volt_reg));
	cov_alert_pin: cover property (!pwm2_pin_oe_n_o && cfg_reg[0]);

endmodule

// [include/thermal_regs_pkg.sv]
/*
 * constants shared by the thermal alert mask and timer register bank:
 * register offsets, field positions, reset values and timing figures.
 * assumes a 100 MHz core clock; times are converted here to cycles, ticks or fast periods.
 */
package thermal_regs_pkg;

	// core clock
	localparam int unsigned CLK_PERIOD_NS = 10;

	// register offsets
	localparam logic [7:0] OFF_ALERT_MASK = 8'h75;
	localparam logic [7:0] OFF_VOLT_LOW = 8'h76;
	localparam logic [7:0] OFF_TEMP_LOW = 8'h77;
	localparam logic [7:0] OFF_CONFIG = 8'h78;
	localparam logic [7:0] OFF_TIMER = 8'h79;
	localparam logic [7:0] OFF_LIMIT = 8'h7a;
	localparam logic [7:0] OFF_ALERT_STATUS = 8'h80;
	// high bytes of the five readings, in channel order
	localparam logic [7:0] OFF_RESULT_BASE = 8'h81;

	// reset values
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] TIMER_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] LIMIT_RESET = 8'h00;

	// reading channels
	localparam int unsigned NUM_CHAN = 5;
	localparam logic [2:0] CH_V25 = 3'h0;
	localparam logic [2:0] CH_VCC = 3'h1;
	localparam logic [2:0] CH_REM1 = 3'h2;
	localparam logic [2:0] CH_LOCAL = 3'h3;
	localparam logic [2:0] CH_REM2 = 3'h4;

	// alert mask and alert status bit positions
	localparam int unsigned BIT_OVERTEMP = 1;
	localparam int unsigned BIT_FAN_ONE = 2;
	localparam int unsigned BIT_FAN_FOUR = 5;
	localparam int unsigned BIT_DIODE_ONE = 6;
	localparam logic [7:0] MASK_WRITABLE = 8'hfc;
	localparam logic [7:0] STATUS_USED = 8'hfe;

	// configuration bit positions
	localparam int unsigned CFG_ALERT_PIN = 0;
	localparam int unsigned CFG_MONITOR = 1;
	localparam int unsigned CFG_FULL_SPEED_ON_THERMAL = 2;
	localparam int unsigned CFG_FAST = 3;
	localparam int unsigned CFG_CONT_LO = 4;

	// timing
	localparam int unsigned TICK_US = 22760;
	localparam int unsigned THRESH_US = 45520;
	localparam int unsigned TACH_FAST_MS = 250;
	localparam int unsigned TACH_SLOW_MS = 1000;
	localparam int unsigned TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned TACH_FAST_CYCLES = TACH_FAST_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [7:0] THRESH_TICKS = 8'(THRESH_US / TICK_US);
	localparam logic [1:0] TACH_SLOW_LAST = 2'(TACH_SLOW_MS / TACH_FAST_MS - 1);

endpackage

// [verif/fan_side_model.sv]
/*
 * far-side model of the bank: fans showing a fixed pwm pattern, a pwm2
 * level and an open-drain thermal pin. assumes clk_i of the bank; the pin
 * goes to its pull-up level whenever the model releases it.
 */
`timescale 1ns/1ps
module fan_side_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic hot_i,
	output logic thermal_pin_n_o,
	output logic [3:0] fan_pwm_o,
	output logic pwm2_o
);
	// released pin floats up, so idle is high and never the last driven level
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thermal_pin_n_o <= 1'b1;
		end else begin
			thermal_pin_n_o <= ~hot_i;
		end
	end
	// pattern differs from all ones so a full_speed_on_thermal is visible
	assign fan_pwm_o = 4'h5;
	assign pwm2_o = 1'b1;
endmodule

// [verif/thermal_alert_mask_and_timer_regs_tb.sv]
/*
 * self-checking bench for the alert mask and timer register bank.
 * assumes the bank's package and a shortened tick and tach period.
 */
`timescale 1ns/1ps
module thermal_alert_mask_and_timer_regs_tb;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic adc_valid_i = 1'b0;
	logic overtemp_i = 1'b0;
	logic input_four_thermal_i = 1'b0;
	logic ce = 1'b1;
	logic hot = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic [2:0] adc_chan_i = 3'h0;
	logic [9:0] adc_data_i = 10'h000;
	logic [3:0] fan_fault_i = 4'h0;
	logic [1:0] diode_fault_i = 2'h0;
	logic [7:0] rdata_o;
	logic [3:0] fan_pwm_i;
	logic [3:0] fan_pwm_o;
	logic [3:0] tach_continuous_o;
	logic thermal_pin_n;
	logic pwm2_i;
	logic pwm2_pin_o;
	logic pwm2_pin_oe_n_o;
	logic irq_o;
	logic tach_sample_o;
	logic tach_fast_o;
	int mismatches = 0;
	int checks = 0;
	logic [9:0] rv [5] = '{10'h2a5, 10'h15a, 10'h3c7, 10'h0e4, 10'h26a};

	always #5 clk_i = ~clk_i;

	thermal_alert_regs #(.TICK_CYCLES(8), .TACH_CYCLES(10), .NUM_FANS(4)) u_thermal_alert_regs (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .adc_valid_i(adc_valid_i),
		.adc_chan_i(adc_chan_i), .adc_data_i(adc_data_i), .overtemp_i(overtemp_i),
		.fan_fault_i(fan_fault_i), .diode_fault_i(diode_fault_i),
		.input_four_thermal_i(input_four_thermal_i), .thermal_pin_n_i(thermal_pin_n),
		.fan_pwm_i(fan_pwm_i), .pwm2_i(pwm2_i), .fan_pwm_o(fan_pwm_o), .pwm2_pin_o(pwm2_pin_o),
		.pwm2_pin_oe_n_o(pwm2_pin_oe_n_o), .irq_o(irq_o), .tach_sample_o(tach_sample_o),
		.tach_fast_o(tach_fast_o), .tach_continuous_o(tach_continuous_o));

	fan_side_model u_fan_side_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .hot_i(hot),
		.thermal_pin_n_o(thermal_pin_n), .fan_pwm_o(fan_pwm_i), .pwm2_o(pwm2_i));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// settle one ns past the edge so registered outputs have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk(what, exp, rdata_o);
	endtask

	task automatic adc(input logic [2:0] c, input logic [9:0] d);
		@(posedge clk_i);
		adc_valid_i <= 1'b1;
		adc_chan_i <= c;
		adc_data_i <= d;
		@(posedge clk_i);
		adc_valid_i <= 1'b0;
	endtask

	task automatic wait_tach(output int n);
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (tach_sample_o !== 1'b1 && n < 100);
		if (n >= 100) begin
			mismatches++;
			stop_test();
		end
	endtask

	task automatic tach_period(input int exp);
		int n;
		wait_tach(n);
		wait_tach(n);
		chk("tach period", 8'(exp), 8'(n));
	endtask

	task automatic hot_pulse(input int n, input logic [3:0] pwm);
		@(posedge clk_i);
		hot <= 1'b1;
		cyc(n);
		chk("fan pwm", {4'h0, pwm}, {4'h0, fan_pwm_o});
		@(posedge clk_i);
		hot <= 1'b0;
	endtask

	task automatic t_reset();
		rdc("config", thermal_regs_pkg::OFF_CONFIG, 8'h00);
		rdc("timer", thermal_regs_pkg::OFF_TIMER, 8'h00);
		rdc("mask", thermal_regs_pkg::OFF_ALERT_MASK, 8'h02);
		rdc("limit", thermal_regs_pkg::OFF_LIMIT, 8'h00);
		rdc("unmapped", 8'h90, 8'h00);
		chk("pin level", 8'h01, {7'h0, pwm2_pin_o});
		chk("pin enable", 8'h00, {7'h0, pwm2_pin_oe_n_o});
	endtask

	task automatic t_config();
		wr(thermal_regs_pkg::OFF_CONFIG, 8'hf8);
		rdc("config", thermal_regs_pkg::OFF_CONFIG, 8'hf8);
		cyc(1);
		chk("rdata idle", 8'h00, rdata_o);
		chk("fast", 8'h01, {7'h0, tach_fast_o});
		chk("continuous", 8'h0f, {4'h0, tach_continuous_o});
		tach_period(10);
		wr(thermal_regs_pkg::OFF_CONFIG, 8'h50);
		cyc(1);
		chk("fast", 8'h00, {7'h0, tach_fast_o});
		chk("continuous", 8'h05, {4'h0, tach_continuous_o});
		tach_period(40);
		wr(thermal_regs_pkg::OFF_CONFIG, 8'ha0);
		cyc(1);
		chk("continuous", 8'h0a, {4'h0, tach_continuous_o});
		wr(thermal_regs_pkg::OFF_CONFIG, 8'h00);
		wr(thermal_regs_pkg::OFF_ALERT_MASK, 8'hff);
		rdc("mask", thermal_regs_pkg::OFF_ALERT_MASK, 8'hfe);
	endtask

	task automatic t_freeze();
		for (int c = 0; c < 5; c++) begin
			adc(3'(c), rv[c]);
		end
		rdc("volt low", thermal_regs_pkg::OFF_VOLT_LOW, {2'h0, rv[1][1:0], 2'h0, rv[0][1:0]});
		adc(thermal_regs_pkg::CH_V25, 10'h0ff);
		rdc("v25 high", thermal_regs_pkg::OFF_RESULT_BASE, rv[0][9:2]);
		rdc("vcc high", 8'(thermal_regs_pkg::OFF_RESULT_BASE + 1), rv[1][9:2]);
		adc(thermal_regs_pkg::CH_V25, 10'h0ff);
		rdc("v25 new", thermal_regs_pkg::OFF_RESULT_BASE, 8'h3f);
		rdc("temp low", thermal_regs_pkg::OFF_TEMP_LOW, {rv[4][1:0], rv[3][1:0], rv[2][1:0], 2'h0});
		adc(thermal_regs_pkg::CH_LOCAL, 10'h3ff);
		for (int c = 2; c < 5; c++) begin
			rdc("temp high", 8'(thermal_regs_pkg::OFF_RESULT_BASE + c), rv[c][9:2]);
		end
	endtask

	// fan faults on mask bits 2..5, diode faults on 6..7; alert pin in use
	task automatic t_faults();
		wr(thermal_regs_pkg::OFF_CONFIG, 8'h01);
		for (int b = 2; b < 8; b++) begin
			wr(thermal_regs_pkg::OFF_ALERT_MASK, 8'(1 << b));
			if (b < 6) fan_fault_i[b - 2] <= 1'b1;
			else diode_fault_i[b - 6] <= 1'b1;
			@(posedge clk_i);
			fan_fault_i <= 4'h0;
			diode_fault_i <= 2'h0;
			cyc(3);
			chk("masked irq", 8'h00, {7'h0, irq_o});
			chk("pin released", 8'h01, {7'h0, pwm2_pin_oe_n_o});
			wr(thermal_regs_pkg::OFF_ALERT_MASK, 8'h00);
			cyc(2);
			chk("irq", 8'h01, {7'h0, irq_o});
			chk("pin driven", 8'h00, {7'h0, pwm2_pin_oe_n_o});
			chk("pin level", 8'h00, {7'h0, pwm2_pin_o});
			rdc("status", thermal_regs_pkg::OFF_ALERT_STATUS, 8'(1 << b));
			wr(thermal_regs_pkg::OFF_ALERT_STATUS, 8'(1 << b));
			cyc(2);
			chk("irq cleared", 8'h00, {7'h0, irq_o});
		end
		wr(thermal_regs_pkg::OFF_CONFIG, 8'h00);
		// monitoring needs the fourth input in thermal use, else overtemp stays masked
		input_four_thermal_i <= 1'b1;
		overtemp_i <= 1'b1;
		@(posedge clk_i);
		overtemp_i <= 1'b0;
		cyc(3);
		chk("overtemp irq", 8'h00, {7'h0, irq_o});
		chk("pin level", 8'h01, {7'h0, pwm2_pin_o});
		rdc("status", thermal_regs_pkg::OFF_ALERT_STATUS, 8'h02);
		wr(thermal_regs_pkg::OFF_CONFIG, 8'h02);
		rdc("mask", thermal_regs_pkg::OFF_ALERT_MASK, 8'h00);
		chk("overtemp irq", 8'h01, {7'h0, irq_o});
		wr(thermal_regs_pkg::OFF_ALERT_STATUS, 8'h02);
	endtask

	task automatic t_thermal();
		wr(thermal_regs_pkg::OFF_CONFIG, 8'h04);
		input_four_thermal_i <= 1'b1;
		hot_pulse(10, 4'h5);
		cyc(4);
		rdc("timer idle", thermal_regs_pkg::OFF_TIMER, 8'h00);
		wr(thermal_regs_pkg::OFF_CONFIG, 8'h06);
		hot_pulse(6, 4'hf);
		cyc(6);
		chk("fan pwm", 8'h05, {4'h0, fan_pwm_o});
		rdc("timer flag", thermal_regs_pkg::OFF_TIMER, 8'h01);
		rdc("timer read", thermal_regs_pkg::OFF_TIMER, 8'h00);
		rdc("status", thermal_regs_pkg::OFF_ALERT_STATUS, 8'h20);
		wr(thermal_regs_pkg::OFF_ALERT_STATUS, 8'h20);
		wr(thermal_regs_pkg::OFF_LIMIT, 8'h02);
		wr(thermal_regs_pkg::OFF_ALERT_MASK, 8'h20);
		hot_pulse(28, 4'hf);
		cyc(6);
		rdc("timer count", thermal_regs_pkg::OFF_TIMER, 8'h03);
		rdc("status", thermal_regs_pkg::OFF_ALERT_STATUS, 8'h20);
		chk("timer irq", 8'h00, {7'h0, irq_o});
		wr(thermal_regs_pkg::OFF_ALERT_MASK, 8'h00);
		cyc(2);
		chk("timer irq", 8'h01, {7'h0, irq_o});
		wr(thermal_regs_pkg::OFF_ALERT_STATUS, 8'h20);
		wr(thermal_regs_pkg::OFF_LIMIT, 8'h04);
		hot_pulse(28, 4'hf);
		cyc(6);
		rdc("status", thermal_regs_pkg::OFF_ALERT_STATUS, 8'h00);
		rdc("timer count", thermal_regs_pkg::OFF_TIMER, 8'h03);
	endtask

	// a write made while the enable is low must not land
	task automatic t_ce();
		@(posedge clk_i);
		ce <= 1'b0;
		wr(thermal_regs_pkg::OFF_LIMIT, 8'h33);
		ce <= 1'b1;
		rdc("limit frozen", thermal_regs_pkg::OFF_LIMIT, 8'h04);
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_config();
		t_freeze();
		t_faults();
		t_thermal();
		t_ce();
		stop_test();
	end
endmodule
